// ==== hdl/hpf_pattern_pkg.sv ====
// constants shared by the pattern and high-pass register block
package hpf_pattern_pkg;
   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [9:0]  IDX_PAT_HPF   = 10'h02D;
   localparam logic [9:0]  IDX_PAT_OUT   = 10'h02F;
   localparam logic [9:0]  IDX_CTRL      = 10'h03E;
   localparam logic [9:0]  IDX_STATUS    = 10'h03F;
   // ==========================================================
   // field positions
   localparam int unsigned PRNG9_BIT     = 15;
   localparam int unsigned CODE9_LSB     = 9;
   localparam int unsigned CODE10_LSB    = 6;
   localparam int unsigned CODE11_LSB    = 5;
   localparam int unsigned CODE12_LSB    = 2;
   localparam int unsigned K_LSB         = 1;
   localparam int unsigned HPF_ON_BIT    = 0;
   localparam int unsigned SEL_BIT       = 0;
   localparam int unsigned COUNT_LSB     = 16;
   // writable bits; reserved bits are dropped and read as zero
   localparam logic [15:0] MASK_PAT_HPF  = 16'hFFDF;
   localparam logic [15:0] MASK_PAT_OUT  = 16'h00FC;
   // ==========================================================
   // reset values
   localparam logic [15:0] RST_PAT_HPF   = 16'h0000;
   localparam logic [15:0] RST_PAT_OUT   = 16'h0000;
   localparam logic        RST_SEL       = 1'b0;
   localparam logic [14:0] PRBS_SEED     = 15'h7FFF;
   // ==========================================================
   // data path widths
   localparam int unsigned SAMPLE_W      = 14;
   localparam int unsigned FRAC_W        = 6;
   localparam int unsigned ACC_W         = 24;
   // ==========================================================
   // pattern codes
   localparam logic [2:0]  PAT_NORMAL    = 3'h0;
   localparam logic [2:0]  PAT_ZEROS     = 3'h1;
   localparam logic [2:0]  PAT_ONES      = 3'h2;
   localparam logic [2:0]  PAT_TOGGLE    = 3'h3;
   localparam logic [2:0]  PAT_RAMP      = 3'h4;
   localparam logic [13:0] TOGGLE_A      = 14'h2AAA;
   localparam logic [13:0] TOGGLE_B      = 14'h1555;
endpackage : hpf_pattern_pkg

// ==== hdl/hpf_stage.sv ====
// first-order digital high-pass filter for one channel
`timescale 1ns/10ps
module hpf_stage (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               on,
   input  wire logic [3:0]         k,
   input  wire logic               in_valid,
   input  wire logic signed [13:0] x,
   output      logic               y_valid,
   output      logic signed [13:0] y
);
   localparam int unsigned F = hpf_pattern_pkg::FRAC_W;
   localparam int unsigned W = hpf_pattern_pkg::ACC_W;

   logic signed [W-1:0] x1;
   logic signed [W-1:0] y1;
   wire  signed [W-1:0] x_ext = W'(x) <<< F;
   // ==========================================================
   // 2^k/(2^k+1) = 1 - 2^-k + 2^-2k - 2^-3k ... four terms
   // trade-off: no divider, error below 2^-4k of the sum
   wire  signed [W-1:0] sum   = x_ext - x1 + y1;
   wire         [5:0]   sh1   = {2'b00, k};
   wire         [5:0]   sh2   = {1'b0, k, 1'b0};
   wire         [5:0]   sh3   = sh1 + sh2;
   wire  signed [W-1:0] next_y = sum - (sum >>> sh1) + (sum >>> sh2)
                                 - (sum >>> sh3);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         x1      <= '0;
         y1      <= '0;
         y       <= '0;
         y_valid <= 1'b0;
      end else begin
         y_valid <= in_valid;
         if (in_valid && on) begin
            x1 <= x_ext;
            y1 <= next_y;
            y  <= next_y[F +: 14];
         end else if (in_valid) begin
            // bypass clears the output history; the input one runs on
            x1 <= x_ext;
            y1 <= '0;
            y  <= x;
         end
      end
   end

   // ==========================================================
   // checks
   hpf_still_a : assert property (@(posedge clk) disable iff (!reset_n)
      on && in_valid && x_ext == x1 && y1 == '0 |=> y == '0)
      else $error("filter output not zero for steady input");
endmodule : hpf_stage

// ==== hdl/lvds_pattern_hpf_ch9_12_regs.sv ====
// register bank, test patterns and high-pass filters, lines 9 to 12
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps
// Summary of operation
// - with selection on, bits 15..12 put pseudo-random data on lines 9..12
// - with selection on, bits 11..9 and 8..6 code patterns on lines 9, 10
// - second register bits 7..5 and 4..2 code patterns on lines 11, 12
// - bit 0 turns the group's high-pass filter on; zero bypasses it
// - bits 4..1 give the filter parameter k for all four channels
// - y(n) = 2^k/(2^k+1)(x(n)-x(n-1)+y(n-1)), history kept per channel
module lvds_pattern_hpf_ch9_12_regs (
   input  wire logic        SYS_CLK,
   input  wire logic        RESET_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output      logic [31:0] HRDATA,
   output      logic        HREADYOUT,
   output      logic        HRESP,
   input  wire logic        SAMPLE_VALID,
   input  wire logic [13:0] SAMPLE_CH9,
   input  wire logic [13:0] SAMPLE_CH10,
   input  wire logic [13:0] SAMPLE_CH11,
   input  wire logic [13:0] SAMPLE_CH12,
   output      logic        LINE_VALID,
   output      logic [13:0] LINE_OUT9,
   output      logic [13:0] LINE_OUT10,
   output      logic [13:0] LINE_OUT11,
   output      logic [13:0] LINE_OUT12
);
   // ==========================================================
   // decode helpers
   function automatic logic [2:0] pattern_code(
      input int unsigned ch,
      input logic [15:0] hpf_reg,
      input logic [15:0] out_reg);
      logic [2:0] code;
      code = '0;
      case (ch)
         0:       code = hpf_reg[hpf_pattern_pkg::CODE9_LSB +: 3];
         1:       code = hpf_reg[hpf_pattern_pkg::CODE10_LSB +: 3];
         2:       code = out_reg[hpf_pattern_pkg::CODE11_LSB +: 3];
         default: code = out_reg[hpf_pattern_pkg::CODE12_LSB +: 3];
      endcase
      return code;
   endfunction : pattern_code

   function automatic logic [13:0] pattern_value(
      input logic [2:0]  code,
      input logic [13:0] data,
      input logic [13:0] ramp);
      logic [13:0] v;
      v = data;
      case (code)
         hpf_pattern_pkg::PAT_ZEROS:  v = '0;
         hpf_pattern_pkg::PAT_ONES:   v = '1;
         hpf_pattern_pkg::PAT_TOGGLE: v = ramp[0] ? hpf_pattern_pkg::TOGGLE_B
                                                  : hpf_pattern_pkg::TOGGLE_A;
         hpf_pattern_pkg::PAT_RAMP:   v = ramp;
         default:                     v = data;
      endcase
      return v;
   endfunction : pattern_value

   // ==========================================================
   // bus slave, zero wait states, always OKAY
   logic        wr_pend;
   logic [9:0]  wr_idx;
   logic [15:0] pat_hpf;
   logic [15:0] pat_out;
   logic        sel;
   logic [15:0] line_count;

   wire         take     = HSEL & HREADY & HTRANS[1];
   wire  [9:0]  addr_idx = HADDR[11:2];
   wire         wr_hpf   = wr_pend && (wr_idx == hpf_pattern_pkg::IDX_PAT_HPF);
   wire         wr_out   = wr_pend && (wr_idx == hpf_pattern_pkg::IDX_PAT_OUT);
   wire         wr_ctl   = wr_pend && (wr_idx == hpf_pattern_pkg::IDX_CTRL);
   // reserved bits are not stored, so a stray one never reaches logic
   wire  [15:0] next_pat_hpf = wr_hpf
                ? (HWDATA[15:0] & hpf_pattern_pkg::MASK_PAT_HPF) : pat_hpf;
   wire  [15:0] next_pat_out = wr_out
                ? (HWDATA[15:0] & hpf_pattern_pkg::MASK_PAT_OUT) : pat_out;
   wire         next_sel     = wr_ctl
                ? HWDATA[hpf_pattern_pkg::SEL_BIT] : sel;
   wire         hpf_on   = pat_hpf[hpf_pattern_pkg::HPF_ON_BIT];
   wire  [3:0]  hpf_k    = pat_hpf[hpf_pattern_pkg::K_LSB +: 4];

   // read data of the three writable registers use the next values so a read right after a write sees it
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = '0;
      case (addr_idx)
         hpf_pattern_pkg::IDX_PAT_HPF: next_rdata = {16'h0000, next_pat_hpf};
         hpf_pattern_pkg::IDX_PAT_OUT: next_rdata = {16'h0000, next_pat_out};
         hpf_pattern_pkg::IDX_CTRL:    next_rdata = {31'h0000_0000, next_sel};
         hpf_pattern_pkg::IDX_STATUS:  next_rdata = {line_count, 14'h0000,
                                                     sel, hpf_on};
         default:                      next_rdata = '0;
      endcase
      if (!(take && !HWRITE))
         next_rdata = '0;
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         wr_pend   <= 1'b0;
         wr_idx    <= '0;
         HRDATA    <= '0;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         wr_pend   <= take && HWRITE;
         wr_idx    <= addr_idx;
         HRDATA    <= next_rdata;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         pat_hpf <= hpf_pattern_pkg::RST_PAT_HPF;
         pat_out <= hpf_pattern_pkg::RST_PAT_OUT;
         sel     <= hpf_pattern_pkg::RST_SEL;
      end else begin
         pat_hpf <= next_pat_hpf;
         pat_out <= next_pat_out;
         sel     <= next_sel;
      end
   end

   // ==========================================================
   // per-channel filter, pseudo-random source and line selection
   logic [13:0] sample [4];
   logic [13:0] line   [4];
   logic [13:0] filt   [4];
   logic [14:0] prbs   [4];
   logic [3:0]  filt_valid;
   logic [13:0] ramp;

   assign sample[0] = SAMPLE_CH9;
   assign sample[1] = SAMPLE_CH10;
   assign sample[2] = SAMPLE_CH11;
   assign sample[3] = SAMPLE_CH12;

   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : g_line
         logic [13:0] y;
         wire         prng_on = pat_hpf[hpf_pattern_pkg::PRNG9_BIT - ch];
         wire  [2:0]  code    = pattern_code(ch, pat_hpf, pat_out);
         wire  [13:0] picked  = !sel    ? filt[ch]
                              : prng_on ? prbs[ch][13:0]
                              : pattern_value(code, filt[ch], ramp);
         assign filt[ch] = y;

         hpf_stage u_hpf (
            .clk      (SYS_CLK),
            .reset_n  (RESET_N),
            .on       (hpf_on),
            .k        (hpf_k),
            .in_valid (SAMPLE_VALID),
            .x        (sample[ch]),
            .y_valid  (filt_valid[ch]),
            .y        (y)
         );

         // seeds differ per line so the four streams do not match
         always_ff @(posedge SYS_CLK) begin
            if (!RESET_N) begin
               prbs[ch] <= hpf_pattern_pkg::PRBS_SEED ^ 15'(ch);
               line[ch] <= '0;
            end else if (filt_valid[ch]) begin
               prbs[ch] <= {prbs[ch][13:0], prbs[ch][14] ^ prbs[ch][13]};
               line[ch] <= picked;
            end
         end
      end
   endgenerate

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         ramp       <= '0;
         line_count <= '0;
         LINE_VALID <= 1'b0;
      end else begin
         LINE_VALID <= filt_valid[0];
         if (filt_valid[0])
            ramp <= ramp + 14'h0001;
         if (filt_valid[0])
            line_count <= line_count + 16'h0001;
      end
   end

   assign LINE_OUT9  = line[0];
   assign LINE_OUT10 = line[1];
   assign LINE_OUT11 = line[2];
   assign LINE_OUT12 = line[3];

   // ==========================================================
   // checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   prng_line9_a : assert property (
      filt_valid[0] && sel && pat_hpf[15]
      |=> LINE_OUT9 == $past(prbs[0][13:0]))
      else $error("line 9 not driven by pseudo-random source");

   prng_line12_a : assert property (
      filt_valid[3] && sel && pat_hpf[12]
      |=> LINE_OUT12 == $past(prbs[3][13:0]))
      else $error("line 12 not driven by pseudo-random source");

   code_line9_a : assert property (
      filt_valid[0] && sel && !pat_hpf[15]
      && pat_hpf[11:9] == hpf_pattern_pkg::PAT_ZEROS
      |=> LINE_OUT9 == 14'h0000)
      else $error("line 9 pattern code ignored");

   code_line11_a : assert property (
      filt_valid[2] && sel && !pat_hpf[13]
      && pat_out[7:5] == hpf_pattern_pkg::PAT_ONES
      |=> LINE_OUT11 == 14'h3FFF)
      else $error("line 11 pattern code ignored");

   hpf_bypass_a : assert property (
      SAMPLE_VALID && !hpf_on && !sel ##1 !sel
      |=> LINE_OUT10 == $past(SAMPLE_CH10, 2))
      else $error("bypassed filter altered line 10");

   k_field_a : assert property (
      wr_hpf |=> hpf_k == $past(HWDATA[4:1])
      ##1 ($stable(hpf_k) || $past(wr_hpf)))
      else $error("filter parameter not taken from write");

   reserved_zero_a : assert property (
      wr_out ##[0:2] HSEL && HREADY && HTRANS[1] && !HWRITE
      && addr_idx == hpf_pattern_pkg::IDX_PAT_OUT
      |=> HRDATA[15:8] == 8'h00 && HRDATA[1:0] == 2'b00)
      else $error("reserved bits read back non-zero");

   prng_line10_a : assert property (
      filt_valid[1] && sel && pat_hpf[14]
      |=> LINE_OUT10 == $past(prbs[1][13:0]))
      else $error("line 10 not driven by pseudo-random source");

   prng_line11_a : assert property (
      filt_valid[2] && sel && pat_hpf[13]
      |=> LINE_OUT11 == $past(prbs[2][13:0]))
      else $error("line 11 not driven by pseudo-random source");

   // an all-zero state would lock the sequence for good
   prbs_alive_a : assert property (
      prbs[0] != 15'h0000 && prbs[1] != 15'h0000
      && prbs[2] != 15'h0000 && prbs[3] != 15'h0000)
      else $error("pseudo-random source stuck at zero");

   code_line10_a : assert property (
      filt_valid[1] && sel && !pat_hpf[14]
      && pat_hpf[8:6] == hpf_pattern_pkg::PAT_ONES
      |=> LINE_OUT10 == 14'h3FFF)
      else $error("line 10 pattern code ignored");

   ramp_line9_a : assert property (
      filt_valid[0] && sel && !pat_hpf[15]
      && pat_hpf[11:9] == hpf_pattern_pkg::PAT_RAMP
      |=> LINE_OUT9 == $past(ramp))
      else $error("line 9 ramp pattern wrong");

   toggle_line11_a : assert property (
      filt_valid[2] && sel && !pat_hpf[13]
      && pat_out[7:5] == hpf_pattern_pkg::PAT_TOGGLE
      |=> LINE_OUT11 == hpf_pattern_pkg::TOGGLE_A
      || LINE_OUT11 == hpf_pattern_pkg::TOGGLE_B)
      else $error("line 11 toggle pattern wrong");

   code_line12_a : assert property (
      filt_valid[3] && sel && !pat_hpf[12]
      && pat_out[4:2] == hpf_pattern_pkg::PAT_ZEROS
      |=> LINE_OUT12 == 14'h0000)
      else $error("line 12 pattern code ignored");

   hpf_enable_a : assert property (
      wr_hpf
      |=> hpf_on == $past(HWDATA[0]))
      else $error("filter enable not taken from write");

   bypass_line12_a : assert property (
      SAMPLE_VALID && !hpf_on && !sel ##1 !sel
      |=> LINE_OUT12 == $past(SAMPLE_CH12, 2))
      else $error("bypassed filter altered line 12");

   k_hold_a : assert property (
      !wr_hpf
      |=> $stable(hpf_k))
      else $error("filter parameter moved without a write");

   line_pulse_a : assert property (
      SAMPLE_VALID
      |-> ##2 LINE_VALID)
      else $error("output pulse missing after a sample");
endmodule : lvds_pattern_hpf_ch9_12_regs

// ==== tb/lvds_line_sink.sv ====
// receiver model standing on the four output lines
`timescale 1ns/10ps
module lvds_line_sink (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        valid,
   input  wire logic [13:0] line9,
   input  wire logic [13:0] line10,
   input  wire logic [13:0] line11,
   input  wire logic [13:0] line12,
   output      logic [13:0] seen [4],
   output      logic [15:0] count
);
   // ==========================================================
   // capture
   // lines only mean something on the pulse, so nothing else is taken
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count <= 16'h0000;
      end else if (valid) begin
         count <= count + 16'h0001;
         seen  <= '{line9, line10, line11, line12};
      end
   end
endmodule : lvds_line_sink

// ==== tb/lvds_pattern_hpf_ch9_12_regs_test.sv ====
// self-checking bench for the pattern and high-pass register block
`timescale 1ns/10ps
module lvds_pattern_hpf_ch9_12_regs_test;
   // ==========================================================
   // signals
   localparam logic [31:0] A_HPF  = 32'({hpf_pattern_pkg::IDX_PAT_HPF,2'b00});
   localparam logic [31:0] A_OUT  = 32'({hpf_pattern_pkg::IDX_PAT_OUT,2'b00});
   localparam logic [31:0] A_CTRL = 32'({hpf_pattern_pkg::IDX_CTRL,2'b00});
   localparam logic [31:0] A_STAT = 32'({hpf_pattern_pkg::IDX_STATUS,2'b00});
   logic        SYS_CLK, RESET_N, HSEL, HWRITE, SAMPLE_VALID;
   logic [31:0] HADDR, HWDATA, r;
   logic [1:0]  HTRANS;
   logic [13:0] x_in;
   logic [13:0] seen [4];
   logic [15:0] count;
   wire  [31:0] HRDATA;
   wire         HREADYOUT, HRESP, LINE_VALID, HREADY;
   wire  [13:0] LINE_OUT9, LINE_OUT10, LINE_OUT11, LINE_OUT12;
   int          failures, total_checks, cycles;
   assign HREADY = HREADYOUT;
   lvds_pattern_hpf_ch9_12_regs u_dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SAMPLE_VALID(SAMPLE_VALID),
      .SAMPLE_CH9(x_in), .SAMPLE_CH10(x_in), .SAMPLE_CH11(x_in),
      .SAMPLE_CH12(x_in), .LINE_VALID(LINE_VALID), .LINE_OUT9(LINE_OUT9),
      .LINE_OUT10(LINE_OUT10), .LINE_OUT11(LINE_OUT11),
      .LINE_OUT12(LINE_OUT12));
   lvds_line_sink u_sink (.clk(SYS_CLK), .reset_n(RESET_N),
      .valid(LINE_VALID), .line9(LINE_OUT9), .line10(LINE_OUT10),
      .line11(LINE_OUT11), .line12(LINE_OUT12), .seen(seen), .count(count));
   // ==========================================================
   // shared tasks
   task automatic stop_test();
      if (failures == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // single word transfer; waits on ready, read data taken at the last edge
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
      @(posedge SYS_CLK);
      HSEL <= 1'b1; HTRANS <= 2'b10; HWRITE <= w; HADDR <= a;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0; HTRANS <= 2'b00; HWDATA <= d;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      r = HRDATA;
   endtask : bus
   // one sample set; the line pulse lands two cycles after it is taken
   task automatic send(input logic [13:0] x);
      logic [15:0] c0;
      c0 = count;
      @(posedge SYS_CLK);
      SAMPLE_VALID <= 1'b1; x_in <= x;
      @(posedge SYS_CLK);
      SAMPLE_VALID <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
      #1;
      chk(32'(count), 32'(c0 + 16'h0001));
   endtask : send
   // ==========================================================
   // scenarios
   task automatic t_regs();
      bus(0, A_HPF, 0); chk(r, 32'h0000_0000);
      bus(0, A_OUT, 0); chk(r, 32'h0000_0000);
      bus(0, 32'h0000_0000, 0); chk(r, 32'h0000_0000);
      // writable bits other than the filter enable read back as written
      bus(1, A_HPF, 32'h0000_FFDE); bus(0, A_HPF, 0);
      chk(r, 32'h0000_FFDE);
      chk(32'({HRESP, HREADYOUT}), 32'h0000_0001);
      bus(1, A_OUT, 32'h0000_00FC); bus(0, A_OUT, 0);
      chk(r, 32'h0000_00FC);
      // selection still off: pattern fields must not touch the data
      send(14'h0123);
      foreach (seen[i]) chk(32'(seen[i]), 32'h0000_0123);
      bus(1, A_HPF, 0); bus(1, A_OUT, 0);
      send(14'h3F00);
      foreach (seen[i]) chk(32'(seen[i]), 32'h0000_3F00);
   endtask : t_regs
   task automatic t_filter(input int k);
      real a, y, xp, xv;
      int  d;
      a = (2.0 ** k) / ((2.0 ** k) + 1.0); y = 0.0; xp = 0.0;
      // a bypassed zero clears both history words before the filter runs
      send(14'h0000);
      foreach (seen[i]) chk(32'(seen[i]), 32'h0000_0000);
      bus(1, A_HPF, 32'(k * 2 + 1)); // k kept within 2..10
      for (int n = 0; n < 5; n++) begin
         xv = (n == 0) ? 0.0 : 1000.0;
         y = a * (xv - xp + y); xp = xv;
         send((n == 0) ? 14'h0000 : 14'h03E8);
         // fixed-point gain approximation, so allow a small error band
         foreach (seen[i]) begin
            d = int'($signed(seen[i])) - $rtoi(y);
            chk(32'(d < 12 && d > -12), 32'h0000_0001);
         end
      end
      bus(1, A_HPF, 0);
   endtask : t_filter
   task automatic t_codes();
      logic [2:0]  c3;
      logic [13:0] p [4];
      bus(1, A_CTRL, 32'h0000_0001);
      bus(0, A_CTRL, 0); chk(r, 32'h0000_0001);
      bus(0, A_STAT, 0); chk(r, {count, 16'h0002});
      for (int c = 0; c < 8; c++) begin
         c3 = c[2:0];
         bus(1, A_HPF, 32'({c3, c3, 6'h00}));
         bus(1, A_OUT, 32'({c3, c3, 2'b00}));
         send(14'h0123); p = seen; send(14'h0123);
         foreach (seen[i]) begin
            if (c == 3) chk(32'((seen[i] == hpf_pattern_pkg::TOGGLE_A ||
               seen[i] == hpf_pattern_pkg::TOGGLE_B) && seen[i] != p[i]),
               32'h0000_0001);
            else if (c == 4) chk(32'(seen[i]), 32'(p[i] + 14'h0001));
            else chk(32'(seen[i]), c == 1 ? 32'h0000_0000 :
               c == 2 ? 32'h0000_3FFF : 32'h0000_0123);
         end
      end
      // each line runs its own sequence, which moves every output
      bus(1, A_HPF, 32'h0000_F000); bus(1, A_OUT, 0);
      send(14'h0000); p = seen; send(14'h0000);
      chk(32'(seen[0] != seen[1] && seen[2] != seen[3]),
          32'h0000_0001);
      foreach (seen[i]) chk(32'(seen[i] != p[i]), 32'h0000_0001);
      bus(1, A_HPF, 0); bus(1, A_CTRL, 0);
   endtask : t_codes
   // ==========================================================
   // clock, timeout and main sequence
   initial begin
      SYS_CLK = 1'b0;
      forever #2 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end
   initial begin
      failures = 0; total_checks = 0;
      RESET_N = 1'b0; HSEL = 1'b0; HWRITE = 1'b0; HTRANS = 2'b00;
      HADDR = 32'h0000_0000; HWDATA = 32'h0000_0000;
      SAMPLE_VALID = 1'b0; x_in = 14'h0000;
      repeat (10) @(posedge SYS_CLK);
      RESET_N <= 1'b1;
      t_regs();
      t_filter(2);
      t_filter(10);
      t_codes();
      stop_test();
   end
endmodule : lvds_pattern_hpf_ch9_12_regs_test
